// >>> src/pll_clock_defines.svh
`ifndef PLL_CLOCK_DEFINES_SVH
`define PLL_CLOCK_DEFINES_SVH

// ==========================================================
// Register byte offsets on the APB
`define OFS_LOOP_CONTROL       12'h000
`define OFS_BANDWIDTH_CONTROL  12'h004
`define OFS_LOOP_PROGRAMMING   12'h008

// ==========================================================
// Field positions
`define LC_IRQ_EN_BIT          7
`define LC_FLAG_BIT            6
`define LC_LOOP_ON_BIT         5
`define LC_SRC_SEL_BIT         4
`define BW_AUTO_BIT            7
`define BW_LOCK_BIT            6
`define BW_ACQ_BIT             5
`define BW_XLOSS_BIT           4
`define PG_MUL_MSB             7
`define PG_MUL_LSB             4
`define PG_RANGE_MSB           3
`define PG_RANGE_LSB           0

// ==========================================================
// Reset and fixed values
`define UNUSED_ONES_VALUE      4'hF
`define TEST_BITS_VALUE        4'h0
`define RST_MULTIPLIER         4'h6
`define RST_RANGE              4'h6
`define MUL_ZERO_AS            4'h1

// ==========================================================
// Timing
`define SWITCH_EDGES           2'h3

`endif

// >>> src/pll_clock_pkg.sv
package pll_clock_pkg;

  typedef logic [11:0] apb_addr_t;
  typedef logic [31:0] apb_data_t;
  typedef logic [7:0]  reg_byte_t;
  typedef logic [3:0]  nibble_t;

  typedef enum logic [1:0] {
    SEL_LOOP_CONTROL,
    SEL_BANDWIDTH,
    SEL_PROGRAMMING,
    SEL_NONE
  } reg_sel_e;

  typedef enum logic {
    SW_RUN,
    SW_SWITCH
  } switch_state_e;

endpackage

// >>> src/pll_clock_gen_control.sv
`timescale 1ns/1ps
`include "pll_clock_defines.svh"


module pll_clock_gen_control (
  input  wire logic                     clk_sys,
  input  wire logic                     srst,
  input  wire pll_clock_pkg::apb_addr_t paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire pll_clock_pkg::apb_data_t pwdata,
  input  wire logic [3:0]               pstrb,
  output logic                          pready,
  output pll_clock_pkg::apb_data_t      prdata,
  output logic                          pslverr,
  input  wire logic                     oscEnableIn,
  input  wire logic                     stopIn,
  input  wire logic                     crystalClockIn,
  input  wire logic                     loopClockIn,
  input  wire logic                     lockDetectIn,
  input  wire logic                     trackDetectIn,
  output logic                          crystalOscEnable,
  output logic                          loopEnable,
  output pll_clock_pkg::nibble_t        feedbackMultiplier,
  output pll_clock_pkg::nibble_t        rangeMultiplier,
  output logic                          filterAutoMode,
  output logic                          filterTrackMode,
  output logic                          crystalClock,
  output logic                          baseClockOut,
  output logic                          lockIrqOut
);
  import pll_clock_pkg::*;

  // ==========================================================
  // Helpers
  function automatic reg_sel_e decodeAddr(input apb_addr_t addr);
    reg_sel_e sel;
    sel = SEL_NONE;
    if (addr == `OFS_LOOP_CONTROL) begin
      sel = SEL_LOOP_CONTROL;
    end else if (addr == `OFS_BANDWIDTH_CONTROL) begin
      sel = SEL_BANDWIDTH;
    end else if (addr == `OFS_LOOP_PROGRAMMING) begin
      sel = SEL_PROGRAMMING;
    end
    return sel;
  endfunction

  function automatic logic rising(input logic prev, input logic cur);
    return cur & ~prev;
  endfunction

  // ==========================================================
  // Declarations
  logic [3:0]    syncMeta_q;
  logic [3:0]    syncOut_q;
  logic [3:0]    syncPrev_q;
  logic          xtalRise;
  logic          loopRise;
  logic          lockToggle;
  reg_sel_e      rdSel_q;
  logic          capFlag_q;
  logic          slvErr_q;
  apb_data_t     prdata_q;
  reg_byte_t     readByte;
  reg_sel_e      accSel;
  logic          accessPhase;
  logic          wrAccess;
  logic          lcWrite;
  logic          bwWrite;
  logic          pgWrite;
  logic          irqEn_q;
  logic          lockFlag_q;
  logic          loopOn_q;
  logic          srcSel_q;
  logic          autoMode_q;
  logic          acqManual_q;
  logic          xloss_q;
  nibble_t       mul_q;
  nibble_t       range_q;
  logic          wantOn;
  logic          wantSel;
  logic          onChange;
  logic          selChange;
  logic          bothChange;
  logic          rangeZero;
  logic          flagClear;
  logic          irqEnVis;
  logic          flagVis;
  logic          lockVis;
  logic          acqVis;
  logic          xlossVis;
  switch_state_e swState_q;
  logic          activeSel_q;
  logic [1:0]    xtalEdges_q;
  logic [1:0]    loopEdges_q;
  logic          baseClock_q;
  logic          selRise;
  logic          xtalDone;
  logic          loopDone;
  logic          crystalOscEnable_q;
  logic          loopEnable_q;
  nibble_t       feedbackMultiplier_q;
  logic          crystalClock_q;
  logic          lockIrq_q;

  // ==========================================================
  // Input synchronisers
  // Clock pins are sampled, so each source must stay below
  // a quarter of clk_sys for its edges to be seen.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      syncMeta_q <= 4'h0;
      syncOut_q  <= 4'h0;
      syncPrev_q <= 4'h0;
    end else begin
      syncMeta_q <= {trackDetectIn, lockDetectIn,
                     loopClockIn, crystalClockIn};
      syncOut_q  <= syncMeta_q;
      syncPrev_q <= syncOut_q;
    end
  end

  assign xtalRise   = rising(syncPrev_q[0], syncOut_q[0]);
  assign loopRise   = rising(syncPrev_q[1], syncOut_q[1]);
  assign lockToggle = autoMode_q & (syncOut_q[2] ^ syncPrev_q[2]);

  // ==========================================================
  // Visible register values
  assign irqEnVis  = irqEn_q & autoMode_q;
  assign flagVis   = lockFlag_q & autoMode_q;
  assign lockVis   = syncOut_q[2] & autoMode_q;
  assign acqVis    = autoMode_q ? syncOut_q[3] : acqManual_q;
  assign xlossVis  = xloss_q & srcSel_q;
  assign rangeZero = (range_q == 4'h0);

  always_comb begin
    readByte = 8'h00;
    case (decodeAddr(paddr))
      SEL_LOOP_CONTROL: begin
        readByte = {irqEnVis, flagVis, loopOn_q, srcSel_q,
                    `UNUSED_ONES_VALUE};
      end
      SEL_BANDWIDTH: begin
        readByte = {autoMode_q, lockVis, acqVis, xlossVis,
                    `TEST_BITS_VALUE};
      end
      SEL_PROGRAMMING: begin
        readByte = {mul_q, range_q};
      end
      default: begin
        readByte = 8'h00;
      end
    endcase
  end

  // ==========================================================
  // APB slave: zero wait, read data latched in setup
  assign accessPhase = psel & penable;
  assign accSel      = decodeAddr(paddr);
  assign wrAccess    = accessPhase & pwrite & pstrb[0];
  assign lcWrite     = wrAccess & (accSel == SEL_LOOP_CONTROL);
  assign bwWrite     = wrAccess & (accSel == SEL_BANDWIDTH);
  assign pgWrite     = wrAccess & (accSel == SEL_PROGRAMMING);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdSel_q   <= SEL_NONE;
      capFlag_q <= 1'b0;
      slvErr_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (psel && !penable) begin
      rdSel_q   <= accSel;
      capFlag_q <= readByte[`LC_FLAG_BIT];
      slvErr_q  <= (accSel == SEL_NONE);
      prdata_q  <= {24'h00_0000, readByte};
    end
  end

  assign pready  = 1'b1;
  assign pslverr = accessPhase & slvErr_q;
  assign prdata  = prdata_q;

  // Only a flag the reader actually saw is cleared, so a lock
  // change landing between setup and access is kept.
  assign flagClear = accessPhase & ~pwrite & (rdSel_q == SEL_LOOP_CONTROL)
                     & capFlag_q;

  // ==========================================================
  // Loop control register
  assign wantOn     = pwdata[`LC_LOOP_ON_BIT];
  assign wantSel    = pwdata[`LC_SRC_SEL_BIT];
  assign onChange   = wantOn != loopOn_q;
  assign selChange  = wantSel != srcSel_q;
  assign bothChange = onChange & selChange;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irqEn_q <= 1'b0;
    end else if (lcWrite && autoMode_q) begin
      irqEn_q <= pwdata[`LC_IRQ_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lockFlag_q <= 1'b0;
    end else begin
      lockFlag_q <= (lockFlag_q & ~flagClear) | lockToggle;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      loopOn_q <= 1'b1;
    end else if (lcWrite && onChange && !bothChange) begin
      if (wantOn || !srcSel_q) begin
        loopOn_q <= wantOn;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || stopIn || rangeZero) begin
      srcSel_q <= 1'b0;
    end else if (lcWrite && selChange && !bothChange) begin
      if (!wantSel || loopOn_q) begin
        srcSel_q <= wantSel;
      end
    end
  end

  // ==========================================================
  // Bandwidth control register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      autoMode_q <= 1'b0;
    end else if (bwWrite) begin
      autoMode_q <= pwdata[`BW_AUTO_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      acqManual_q <= 1'b0;
    end else if (bwWrite && !autoMode_q) begin
      acqManual_q <= pwdata[`BW_ACQ_BIT];
    end
  end

  // Armed by writing one while srcSel_q is set; any rising crystal edge since then clears
  // it, so after the wait a one means no reference.
  always_ff @(posedge clk_sys) begin
    if (srst || !srcSel_q) begin
      xloss_q <= 1'b0;
    end else if (bwWrite && pwdata[`BW_XLOSS_BIT]) begin
      xloss_q <= 1'b1;
    end else if (xtalRise) begin
      xloss_q <= 1'b0;
    end
  end

  // ==========================================================
  // Programming register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mul_q <= `RST_MULTIPLIER;
    end else if (pgWrite && !loopOn_q) begin
      mul_q <= pwdata[`PG_MUL_MSB:`PG_MUL_LSB];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      range_q <= `RST_RANGE;
    end else if (pgWrite && !loopOn_q) begin
      range_q <= pwdata[`PG_RANGE_MSB:`PG_RANGE_LSB];
    end
  end

  // ==========================================================
  // Base clock selector
  assign selRise  = activeSel_q ? loopRise : xtalRise;
  assign xtalDone = (xtalEdges_q == `SWITCH_EDGES);
  // A stopped loop gives no edges; do not wait on it forever
  assign loopDone = (loopEdges_q == `SWITCH_EDGES) | ~loopEnable_q;

  always_ff @(posedge clk_sys) begin
    if (srst || stopIn) begin
      swState_q   <= SW_RUN;
      activeSel_q <= 1'b0;
      xtalEdges_q <= 2'h0;
      loopEdges_q <= 2'h0;
      baseClock_q <= 1'b0;
    end else begin
      case (swState_q)
        SW_RUN: begin
          xtalEdges_q <= 2'h0;
          loopEdges_q <= 2'h0;
          if (activeSel_q != srcSel_q) begin
            swState_q <= SW_SWITCH;
          end else if (selRise) begin
            baseClock_q <= ~baseClock_q;
          end
        end
        SW_SWITCH: begin
          if (xtalRise && !xtalDone) begin
            xtalEdges_q <= xtalEdges_q + 2'h1;
          end
          if (loopRise && !loopDone) begin
            loopEdges_q <= loopEdges_q + 2'h1;
          end
          if (xtalDone && loopDone) begin
            activeSel_q <= srcSel_q;
            swState_q   <= SW_RUN;
          end
        end
        default: begin
          swState_q <= SW_RUN;
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs toward oscillator, loop and CPU
  // Stop and oscEnableIn both gate the generator; stop also forces crystalClock and lockIrqOut low.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      crystalOscEnable_q <= 1'b0;
      loopEnable_q       <= 1'b0;
    end else begin
      crystalOscEnable_q <= oscEnableIn & ~stopIn;
      loopEnable_q       <= oscEnableIn & ~stopIn & loopOn_q
                            & ~rangeZero;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      feedbackMultiplier_q <= `RST_MULTIPLIER;
    end else if (mul_q == 4'h0) begin
      feedbackMultiplier_q <= `MUL_ZERO_AS;
    end else begin
      feedbackMultiplier_q <= mul_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      crystalClock_q <= 1'b0;
      lockIrq_q      <= 1'b0;
    end else begin
      crystalClock_q <= syncOut_q[0] & ~stopIn;
      lockIrq_q      <= flagVis & irqEnVis & ~stopIn;
    end
  end

  assign crystalOscEnable   = crystalOscEnable_q;
  assign loopEnable         = loopEnable_q;
  assign feedbackMultiplier = feedbackMultiplier_q;
  assign rangeMultiplier    = range_q;
  assign filterAutoMode     = autoMode_q;
  assign filterTrackMode    = acqManual_q;
  assign crystalClock       = crystalClock_q;
  assign baseClockOut       = baseClock_q;
  assign lockIrqOut         = lockIrq_q;

endmodule

// >>> test/pll_far_side_model.sv
`timescale 1ns/1ps
// ==========
// Oscillator, loop and analog detectors
module pll_far_side_model #(
  parameter int XH = 11,
  parameter int LH = 9
) (
  input  wire logic oscOn,
  input  wire logic loopOn,
  input  wire logic xtalRun,
  input  wire logic lockReq,
  input  wire logic trackReq,
  output logic      crystalClockIn,
  output logic      loopClockIn,
  output logic      lockDetectIn,
  output logic      trackDetectIn
);
  // Stopped clocks stand low, never frozen high
  initial begin
    crystalClockIn = 1'b0;
    forever #XH crystalClockIn = oscOn & xtalRun & ~crystalClockIn;
  end
  initial begin
    loopClockIn = 1'b0;
    forever #LH loopClockIn = loopOn & ~loopClockIn;
  end
  // Detectors mean nothing while the loop is off
  assign lockDetectIn  = loopOn & lockReq;
  assign trackDetectIn = loopOn & trackReq;
endmodule

// >>> test/pll_clock_gen_control_assertions.sv
`timescale 1ns/1ps
`include "pll_clock_defines.svh"
// ==========
// Port checks
module pll_clock_gen_control_assertions (
  input wire logic                     clk_sys,
  input wire logic                     srst,
  input wire pll_clock_pkg::apb_addr_t paddr,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire pll_clock_pkg::apb_data_t pwdata,
  input wire logic [3:0]               pstrb,
  input wire pll_clock_pkg::apb_data_t prdata,
  input wire logic                     pslverr,
  input wire logic                     oscEnableIn,
  input wire logic                     stopIn,
  input wire logic                     crystalOscEnable,
  input wire logic                     loopEnable,
  input wire pll_clock_pkg::nibble_t   feedbackMultiplier,
  input wire pll_clock_pkg::nibble_t   rangeMultiplier,
  input wire logic                     filterAutoMode,
  input wire logic                     crystalClock,
  input wire logic                     baseClockOut,
  input wire logic                     lockIrqOut
);
  import pll_clock_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic rdLc;
  assign rdLc = psel & penable & ~pwrite & (paddr == `OFS_LOOP_CONTROL);

  property p_ones; rdLc |-> prdata[3:0] == 4'hF; endproperty
  a_ones: assert property (p_ones) else $error("low nibble");
  property p_mask; rdLc && !filterAutoMode |-> prdata[7:6] == 2'b00;
  endproperty
  a_mask: assert property (p_mask) else $error("manual mask");
  property p_irqauto; lockIrqOut |-> $past(filterAutoMode); endproperty
  a_irqauto: assert property (p_irqauto) else $error("irq manual");
  property p_rdclr; rdLc && prdata[6] |=> ##1 !lockIrqOut; endproperty
  a_rdclr: assert property (p_rdclr) else $error("flag kept");
  property p_stop;
    stopIn |=> !crystalClock && !baseClockOut && !lockIrqOut;
  endproperty
  a_stop: assert property (p_stop) else $error("stop outputs");
  property p_osc; !oscEnableIn |=> !crystalOscEnable && !loopEnable;
  endproperty
  a_osc: assert property (p_osc) else $error("osc enable");
  property p_range; rangeMultiplier == 4'h0 |=> !loopEnable; endproperty
  a_range: assert property (p_range) else $error("zero range");
  property p_mul; feedbackMultiplier != 4'h0; endproperty
  a_mul: assert property (p_mul) else $error("multiplier zero");
  property p_auto;
    psel && penable && pwrite && pstrb[0] && paddr == `OFS_BANDWIDTH_CONTROL
      |=> filterAutoMode == $past(pwdata[7]);
  endproperty
  a_auto: assert property (p_auto) else $error("auto bit");
  // Source never faster than clk_sys/4, so half period spans 4 cycles
  property p_half;
    disable iff (srst || stopIn)
      $changed(baseClockOut) |=> $stable(baseClockOut)[*3];
  endproperty
  a_half: assert property (p_half) else $error("short pulse");
  c_irq: cover property (lockIrqOut);
  c_base: cover property ($changed(baseClockOut));
  c_err: cover property (psel && penable && pslverr);
endmodule

bind pll_clock_gen_control pll_clock_gen_control_assertions u_chk (
  .clk_sys, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
  .prdata, .pslverr, .oscEnableIn, .stopIn, .crystalOscEnable, .loopEnable,
  .feedbackMultiplier, .rangeMultiplier, .filterAutoMode, .crystalClock,
  .baseClockOut, .lockIrqOut);

// >>> test/pll_clock_gen_control_test.sv
`timescale 1ns/1ps
`include "pll_clock_defines.svh"
// ==========
// Bench
module pll_clock_gen_control_test;
  import pll_clock_pkg::*;
  localparam apb_addr_t LCA = `OFS_LOOP_CONTROL;
  localparam apb_addr_t BWA = `OFS_BANDWIDTH_CONTROL;
  localparam apb_addr_t PGA = `OFS_LOOP_PROGRAMMING;
  logic       clk_sys, srst, psel, penable, pwrite, pready, pslverr;
  logic       oscEnableIn, stopIn, crystalClockIn, loopClockIn, b;
  logic       lockDetectIn, trackDetectIn, crystalOscEnable, loopEnable;
  logic       filterAutoMode, filterTrackMode, crystalClock, err;
  logic       baseClockOut, lockIrqOut, xtalRun, lockReq, trackReq;
  logic [3:0] pstrb;
  apb_addr_t  paddr;
  apb_data_t  pwdata, prdata;
  nibble_t    feedbackMultiplier, rangeMultiplier;
  reg_byte_t  q, v;
  int         errors, testsRun, n;

  pll_clock_gen_control dut (.clk_sys, .srst, .paddr, .psel, .penable,
    .pwrite, .pwdata, .pstrb, .pready, .prdata, .pslverr, .oscEnableIn,
    .stopIn, .crystalClockIn, .loopClockIn, .lockDetectIn, .trackDetectIn,
    .crystalOscEnable, .loopEnable, .feedbackMultiplier, .rangeMultiplier,
    .filterAutoMode, .filterTrackMode, .crystalClock, .baseClockOut,
    .lockIrqOut);
  pll_far_side_model u_far (.oscOn(crystalOscEnable), .loopOn(loopEnable),
    .xtalRun, .lockReq, .trackReq, .crystalClockIn, .loopClockIn,
    .lockDetectIn, .trackDetectIn);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  function automatic reg_byte_t lc(input logic [3:0] f);
    return {f, `UNUSED_ONES_VALUE};
  endfunction
  function automatic reg_byte_t bw(input logic [3:0] f);
    return {f, `TEST_BITS_VALUE};
  endfunction
  function automatic reg_byte_t mulN(input nibble_t m);
    return {4'h0, (m == 4'h0) ? `MUL_ZERO_AS : m};
  endfunction

  task automatic wrap_up();
    if (errors == 0 && testsRun > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input reg_byte_t e, input reg_byte_t g);
    testsRun++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // Setup, then access held until pready is seen high
  task automatic apb(input apb_addr_t a, input logic w, input reg_byte_t d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input apb_addr_t a, input reg_byte_t d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input apb_addr_t a, input string nm, input reg_byte_t e);
    apb(a, 1'b0, 8'h00);
    chk(nm, e, q);
  endtask
  task automatic waitIrq();
    n = 0;
    while (lockIrqOut !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
  endtask
  // Four base periods are eight source periods
  task automatic period(input int half, input string nm);
    realtime t0;
    @(posedge baseClockOut);
    t0 = $realtime;
    repeat (4) @(posedge baseClockOut);
    n = int'(($realtime - t0) / 4.0);
    chk(nm, 8'h01, 8'(n >= 4 * half - 1 && n <= 4 * half + 1));
  endtask

  initial begin
    #200000;
    errors++;
    wrap_up();
  end

  initial begin
    srst = 1'b1;
    {psel, penable, pwrite, stopIn, lockReq, trackReq} = '0;
    {oscEnableIn, xtalRun} = 2'b11;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    errors = 0;
    testsRun = 0;
    v = 8'($urandom(9158));
    cyc(10);
    srst <= 1'b0;
    rd(LCA, "lcReset", lc(4'b0010));
    rd(BWA, "bwReset", bw(4'b0000));
    wr(PGA, 8'h12);
    rd(PGA, "pgLocked", 8'h66);
    wr(LCA, 8'h00);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'h00 : (i == 5) ? 8'h80 : 8'($urandom);
      wr(PGA, v);
      rd(PGA, "pgWrite", v);
      chk("mul", mulN(v[7:4]), 8'(feedbackMultiplier));
      chk("range", {4'h0, v[3:0]}, 8'(rangeMultiplier));
    end
    wr(LCA, 8'h20);
    cyc(2);
    chk("loopZeroRange", 8'h00, 8'(loopEnable));
    wr(LCA, 8'h30);
    rd(LCA, "selZeroRange", lc(4'b0010));
    wr(LCA, 8'h00);
    wr(PGA, 8'h87);
    wr(LCA, 8'h30);
    rd(LCA, "bothChange", lc(4'b0000));
    wr(LCA, 8'h10);
    rd(LCA, "selWhileOff", lc(4'b0000));
    wr(LCA, 8'h20);
    wr(BWA, 8'h80);
    lockReq <= 1'b1;
    cyc(6);
    rd(BWA, "lockAuto", bw(4'b1100));
    rd(LCA, "flagNoIrq", lc(4'b0110));
    chk("irqMasked", 8'h00, 8'(lockIrqOut));
    wr(LCA, 8'h30);
    @(negedge clk_sys);
    b = baseClockOut;
    n = 0;
    while (baseClockOut === b && n < 80) begin
      @(negedge clk_sys);
      n++;
    end
    chk("switchHold", 8'h01, 8'(n >= 8 && n <= 60));
    period(9, "loopBase");
    wr(LCA, 8'h10);
    rd(LCA, "offWhileSel", lc(4'b0011));
    wr(BWA, 8'h90);
    cyc(4 * 8);
    rd(BWA, "xtalAlive", bw(4'b1100));
    xtalRun <= 1'b0;
    cyc(8);
    wr(BWA, 8'h90);
    cyc(4 * 8);
    rd(BWA, "xtalLost", bw(4'b1101));
    wr(LCA, 8'h20);
    rd(BWA, "xldDeselected", bw(4'b1100));
    xtalRun <= 1'b1;
    period(11, "xtalBase");
    wr(LCA, 8'hA0);
    lockReq <= 1'b0;
    waitIrq();
    chk("irqRaised", 8'h01, 8'(lockIrqOut));
    rd(LCA, "flagRead", lc(4'b1110));
    cyc(3);
    chk("irqCleared", 8'h00, 8'(lockIrqOut));
    rd(LCA, "flagGone", lc(4'b1010));
    lockReq <= 1'b1;
    waitIrq();
    chk("irqAgain", 8'h01, 8'(lockIrqOut));
    wr(BWA, 8'h00);
    cyc(2);
    chk("irqManual", 8'h00, 8'(lockIrqOut));
    rd(LCA, "lcManual", lc(4'b0010));
    wr(LCA, 8'h20);
    wr(BWA, 8'h20);
    rd(BWA, "acqManual", bw(4'b0010));
    chk("trackOut", 8'h01, 8'(filterTrackMode));
    wr(BWA, 8'hA0);
    cyc(4);
    rd(BWA, "acqAuto", bw(4'b1100));
    apb(LCA, 1'b0, 8'h00);
    chk("enKept", 8'h80, q & 8'h80);
    wr(BWA, 8'h00);
    rd(BWA, "acqRestored", bw(4'b0010));
    wr(LCA, 8'h30);
    cyc(40);
    stopIn <= 1'b1;
    cyc(4);
    chk("stopOuts", 8'h00, 8'({baseClockOut, crystalClock}));
    stopIn <= 1'b0;
    rd(LCA, "selAfterStop", lc(4'b0010));
    period(11, "wakeBase");
    oscEnableIn <= 1'b0;
    cyc(4);
    chk("oscOff", 8'h00, 8'({crystalOscEnable, loopEnable}));
    oscEnableIn <= 1'b1;
    cyc(4);
    chk("oscOn", 8'h03, 8'({crystalOscEnable, loopEnable}));
    pstrb <= 4'h0;
    wr(BWA, 8'h80);
    pstrb <= 4'hF;
    rd(BWA, "strbOff", bw(4'b0010));
    rd(12'h00C, "unmapped", 8'h00);
    chk("slverr", 8'h01, 8'(err));
    srst <= 1'b1;
    cyc(4);
    srst <= 1'b0;
    rd(LCA, "lcAgain", lc(4'b0010));
    rd(PGA, "pgAgain", 8'h66);
    wrap_up();
  end
endmodule
